// ---- shared/aos_pkg.sv ----
// constants, field layouts and carrier types of the accumulate/output sequencer
// assumes a single 25 MHz clock and a classic wishbone register port
package aos_pkg;
  localparam int          CLK_PERIOD_NS = 40;
  localparam int          ADD_TIME_NS   = 150;
  // longest time rounds down to whole cycles, never below one
  localparam int          ADD_CYCLES    = (ADD_TIME_NS / CLK_PERIOD_NS) < 1 ?
                                          1 : (ADD_TIME_NS / CLK_PERIOD_NS);
  localparam int          ACC_WIDTH     = 20;
  localparam int          PP_WIDTH      = 12;
  localparam int          WL_WIDTH      = 3;
  localparam int          MAX_BITS      = 8;
  // register byte offsets
  localparam logic [7:0]  REG_CTRL      = 8'h00;
  localparam logic [7:0]  REG_STATUS    = 8'h04;
  localparam logic [7:0]  REG_MASK      = 8'h08;
  localparam logic [7:0]  REG_RESULT    = 8'h0C;
  localparam logic [7:0]  REG_STATE     = 8'h10;
  // field positions
  localparam int          CTRL_ENABLE   = 0;
  localparam int          EV_DONE       = 0;
  localparam int          EV_OVERRUN    = 1;
  localparam int          EV_COUNT      = 2;
  localparam int          STATE_BUSY    = 0;
  localparam int          STATE_ACC     = 1;
  localparam logic [31:0] CTRL_RESET    = 32'h0000_0001;
  localparam logic [31:0] MASK_RESET    = 32'h0000_0000;
  localparam logic [ACC_WIDTH-1:0] ACC_ZERO = 20'h0_0000;
  localparam logic [ACC_WIDTH-1:0] ACC_ONES = 20'hF_FFFF;

  // carry-save pair held by the accumulator stages
  typedef struct packed {
    logic [ACC_WIDTH-1:0] sum;
    logic [ACC_WIDTH-1:0] carry;
  } aos_cs_type;
endpackage

// ---- hdl/aos_dyn_adder.sv ----
// output adder of the accumulator: precharge / evaluate carry chain
// assumes capture is a registered pulse two clocks (one phase pair) long
module aos_dyn_adder #(
  parameter int WIDTH = aos_pkg::ACC_WIDTH
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // operands and timing
  input  wire logic             capture,
  input  wire logic [WIDTH-1:0] op_a,
  input  wire logic [WIDTH-1:0] op_b,
  // result
  output logic      [WIDTH-1:0] sum_n,
  output logic                  done
);
  logic [WIDTH-1:0] a_q;
  logic [WIDTH-1:0] b_q;
  logic [WIDTH-1:0] node;
  logic [WIDTH:0]   chain;
  logic             capture_q;
  logic             eval;

  ////////////////////////////////////////////////////////////////////////////
  // operands applied while capture is high, evaluation on its fall
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      a_q <= aos_pkg::ACC_ZERO;
      b_q <= aos_pkg::ACC_ZERO;
    end else if (capture) begin
      a_q <= op_a;
      b_q <= op_b;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      capture_q <= 1'b0;
    end else begin
      capture_q <= capture;
    end
  end

  assign eval = capture_q && !capture;

  ////////////////////////////////////////////////////////////////////////////
  // one cell per bit; carry passes on propagate, or is generated locally
  assign chain[0] = 1'b0;
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_cell
      assign chain[i+1] = (a_q[i] & b_q[i]) |
                          ((a_q[i] ^ b_q[i]) & chain[i]);
    end
  endgenerate

  // carry nodes: all high while precharged, settle on evaluation
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      node <= aos_pkg::ACC_ONES;
    end else if (capture) begin
      node <= aos_pkg::ACC_ONES;
    end else if (eval) begin
      node <= chain[WIDTH-1:0];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sum_n <= aos_pkg::ACC_ONES;
      done  <= 1'b0;
    end else begin
      done <= eval;
      if (eval) begin
        sum_n <= ~(a_q ^ b_q ^ chain[WIDTH-1:0]);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  localparam int ADD_MAX = aos_pkg::ADD_CYCLES;

  property p_precharge;
    @(posedge clk) disable iff (rst)
      capture |=> (node == aos_pkg::ACC_ONES);
  endproperty
  a_precharge: assert property (p_precharge)
    else $error("carry nodes not precharged during capture");

  property p_add_time;
    @(posedge clk) disable iff (rst)
      $fell(capture) |-> ##[1:ADD_MAX] done;
  endproperty
  a_add_time: assert property (p_add_time)
    else $error("adder did not finish within its time");
endmodule

// ---- hdl/aos_sequencer.sv ----
// accumulate/output sequencer: controller, carry-save accumulator,
// output adder and tri-state output latch, with a wishbone register port
// assumes host pins synchronous to clk; result bus wire resolved outside
module aos_sequencer #(
  parameter int WIDTH    = aos_pkg::ACC_WIDTH,
  parameter int PP_W     = aos_pkg::PP_WIDTH,
  parameter int MAX_BITS = aos_pkg::MAX_BITS
) (
  // clock and reset
  input  wire logic                      clk,
  input  wire logic                      rst,
  // wishbone slave
  input  wire logic                      wb_cyc_i,
  input  wire logic                      wb_stb_i,
  input  wire logic                      wb_we_i,
  input  wire logic [7:0]                wb_adr_i,
  input  wire logic [3:0]                wb_sel_i,
  input  wire logic [31:0]               wb_dat_i,
  output logic      [31:0]               wb_dat_o,
  output logic                           wb_ack_o,
  output logic                           irq,
  // host control
  input  wire logic                      load_pulse,
  input  wire logic [aos_pkg::WL_WIDTH-1:0] word_length,
  input  wire logic                      output_enable,
  input  wire logic                      program_write_mode,
  // partial product data from memory
  input  wire logic [PP_W-1:0]           pp_data,
  // control outputs
  output logic                           parallel_load_pulse,
  output logic                           accumulator_clear_pulse,
  output logic                           sum_capture_pulse,
  output logic                           result_hold,
  output logic                           data_valid,
  // result bus
  output logic      [WIDTH-1:0]          result_out,
  output logic                           result_oe
);
  logic                  phase;
  logic                  first_sequence_flop;
  logic                  second_sequence_flop;
  logic                  sequence_set_reset_latch;
  logic [MAX_BITS:0]     chain;
  logic [MAX_BITS-1:0]   tap_selector;
  logic                  tap_hit;
  logic                  acc_run;
  logic                  hold_gate;
  logic                  clear_q;
  logic                  clear_rise;
  aos_pkg::aos_cs_type   master;
  aos_pkg::aos_cs_type   slave;
  aos_pkg::aos_cs_type   next_master;
  logic [WIDTH-1:0]      acc_s;
  logic [WIDTH-1:0]      acc_c;
  logic [WIDTH-1:0]      addend;
  logic [WIDTH-1:0]      adder_sum_n;
  logic                  adder_done;
  logic [31:0]           ctrl;
  logic [31:0]           status;
  logic [31:0]           mask;
  logic [aos_pkg::EV_COUNT-1:0] event_set;
  logic                  wb_hit;
  logic                  wb_wr;
  logic                  overrun;
  logic                  load_ok;

  ////////////////////////////////////////////////////////////////////////////
  // two phases from the one clock: phase low is the capture phase,
  // phase high the transfer phase; they can never overlap
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      phase <= 1'b0;
    end else begin
      phase <= ~phase;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // word length code n selects n+1 bits
  genvar i;
  generate
    for (i = 0; i < MAX_BITS; i++) begin : g_tap
      localparam int WL_W = aos_pkg::WL_WIDTH;
      assign tap_selector[i] = (word_length == WL_W'(i));
    end
  endgenerate
  assign tap_hit = |(chain[MAX_BITS-1:0] & tap_selector);

  // a load while a block is running is dropped, and flagged only while enabled
  assign load_ok = load_pulse && ctrl[aos_pkg::CTRL_ENABLE] &&
                   !first_sequence_flop && !sequence_set_reset_latch;
  assign overrun = load_pulse && ctrl[aos_pkg::CTRL_ENABLE] && !load_ok;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      first_sequence_flop <= 1'b0;
    end else if (load_ok) begin
      first_sequence_flop <= 1'b1;
    end else if (sequence_set_reset_latch) begin
      first_sequence_flop <= 1'b0;
    end
  end

  // sequencer flops advance once per phase pair: second flop and tap
  // chain both on the transfer phase
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      second_sequence_flop <= 1'b0;
      chain                <= '0;
    end else if (phase) begin
      second_sequence_flop <= first_sequence_flop &&
                              !sequence_set_reset_latch;
      chain <= {chain[MAX_BITS-1:0], second_sequence_flop};
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sequence_set_reset_latch <= 1'b0;
    end else if (second_sequence_flop) begin
      sequence_set_reset_latch <= 1'b1;
    end else if (hold_gate && phase) begin
      sequence_set_reset_latch <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      acc_run           <= 1'b0;
      sum_capture_pulse <= 1'b0;
      hold_gate         <= 1'b0;
    end else if (phase) begin
      if (second_sequence_flop) begin
        acc_run <= 1'b1;
      end else if (tap_hit) begin
        acc_run <= 1'b0;
      end
      sum_capture_pulse <= tap_hit;
      hold_gate         <= sum_capture_pulse;
    end
  end

  // one flop feeds both the hold strobe and the valid pulse
  assign result_hold             = hold_gate;
  assign data_valid              = hold_gate;
  assign parallel_load_pulse     = second_sequence_flop;
  assign accumulator_clear_pulse = second_sequence_flop;

  ////////////////////////////////////////////////////////////////////////////
  // carry-save accumulator, slaves hold the inverted words
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      clear_q <= 1'b0;
    end else begin
      clear_q <= accumulator_clear_pulse;
    end
  end
  assign clear_rise = accumulator_clear_pulse && !clear_q;

  assign acc_s  = ~slave.sum;
  assign acc_c  = ~slave.carry;
  assign addend = {{(WIDTH-PP_W){pp_data[PP_W-1]}}, pp_data};

  // previous total is doubled before the new partial product enters
  always_comb begin
    next_master.sum   = {acc_s[WIDTH-2:0], 1'b0} ^
                        {acc_c[WIDTH-2:0], 1'b0} ^ addend;
    next_master.carry = {(({acc_s[WIDTH-3:0], 1'b0} &
                           {acc_c[WIDTH-3:0], 1'b0}) |
                          ({acc_s[WIDTH-3:0], 1'b0} & addend[WIDTH-2:0]) |
                          ({acc_c[WIDTH-3:0], 1'b0} & addend[WIDTH-2:0])),
                         1'b0};
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      master <= '{sum: aos_pkg::ACC_ZERO, carry: aos_pkg::ACC_ZERO};
    end else if (clear_rise) begin
      master <= '{sum: aos_pkg::ACC_ZERO,
                  carry: aos_pkg::ACC_ZERO};
    end else if (!phase && acc_run) begin
      master <= next_master;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      slave <= '{sum: aos_pkg::ACC_ONES, carry: aos_pkg::ACC_ONES};
    end else if (clear_rise) begin
      slave <= '{sum: aos_pkg::ACC_ONES,
                 carry: aos_pkg::ACC_ONES};
    end else if (phase) begin
      slave <= '{sum: ~master.sum, carry: ~master.carry};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // output adder, transfer on the fall of the capture pulse
  aos_dyn_adder #(
    .WIDTH (WIDTH)
  ) u_adder (
    .clk     (clk),
    .rst     (rst),
    .capture (sum_capture_pulse),
    .op_a    (~slave.sum),
    .op_b    (~slave.carry),
    .sum_n   (adder_sum_n),
    .done    (adder_done)
  );

  ////////////////////////////////////////////////////////////////////////////
  // output latch and bus driver
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      result_out <= aos_pkg::ACC_ZERO;
    end else if (hold_gate) begin
      result_out <= ~adder_sum_n;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      result_oe <= 1'b0;
    end else begin
      result_oe <= output_enable && !program_write_mode;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // wishbone slave: ack one cycle after request; writes land with ack
  assign wb_hit = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wb_wr  = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_hit;
      if (wb_hit && !wb_we_i) begin
        unique case (wb_adr_i)
          aos_pkg::REG_CTRL:   wb_dat_o <= ctrl;
          aos_pkg::REG_STATUS: wb_dat_o <= status;
          aos_pkg::REG_MASK:   wb_dat_o <= mask;
          aos_pkg::REG_RESULT: wb_dat_o <= {{(32-WIDTH){1'b0}}, result_out};
          aos_pkg::REG_STATE:  wb_dat_o <= {30'h0000_0000, acc_run,
                                 first_sequence_flop |
                                 sequence_set_reset_latch};
          default:             wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  // writable registers take byte lanes
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl <= aos_pkg::CTRL_RESET;
      mask <= aos_pkg::MASK_RESET;
    end else if (wb_wr) begin
      for (int b = 0; b < 4; b++) begin
        if (wb_sel_i[b] && wb_adr_i == aos_pkg::REG_CTRL) begin
          ctrl[8*b +: 8] <= wb_dat_i[8*b +: 8];
        end
        if (wb_sel_i[b] && wb_adr_i == aos_pkg::REG_MASK) begin
          mask[8*b +: 8] <= wb_dat_i[8*b +: 8];
        end
      end
    end
  end

  // sticky events; a new event wins over a write-one clear
  assign event_set[aos_pkg::EV_DONE]    = hold_gate && phase;
  assign event_set[aos_pkg::EV_OVERRUN] = overrun;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      status <= 32'h0000_0000;
    end else begin
      for (int e = 0; e < aos_pkg::EV_COUNT; e++) begin
        if (event_set[e]) begin
          status[e] <= 1'b1;
        end else if (wb_wr && wb_sel_i[0] &&
                     wb_adr_i == aos_pkg::REG_STATUS && wb_dat_i[e]) begin
          status[e] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status & mask);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_inverted_out;
    phase && !clear_rise |=> slave.sum == ~$past(master.sum);
  endproperty
  a_inverted_out: assert property (p_inverted_out)
    else $error("slave did not present inverted master");

  property p_clear;
    clear_rise |=> master.sum == aos_pkg::ACC_ZERO &&
                   slave.carry == aos_pkg::ACC_ONES;
  endproperty
  a_clear: assert property (p_clear)
    else $error("accumulator not cleared");

  property p_latch_hold;
    !hold_gate |=> $stable(result_out);
  endproperty
  a_latch_hold: assert property (p_latch_hold)
    else $error("output latch changed while holding");

  property p_bus_enable;
    ##1 result_oe |-> $past(output_enable) && !$past(program_write_mode);
  endproperty
  a_bus_enable: assert property (p_bus_enable)
    else $error("result bus driven while not enabled");

  property p_program_float;
    program_write_mode |=> !result_oe;
  endproperty
  a_program_float: assert property (p_program_float)
    else $error("result bus driven in program mode");

  sequence s_load_taken;
    load_ok ##1 first_sequence_flop;
  endsequence
  sequence s_first_to_second;
    ##[1:2] second_sequence_flop ##[1:2] !first_sequence_flop;
  endsequence
  property p_load_seq;
    s_load_taken |-> s_first_to_second;
  endproperty
  a_load_seq: assert property (p_load_seq)
    else $error("load did not step through both sequence flops");

  property p_hold_after_capture;
    $fell(sum_capture_pulse) |-> hold_gate ##2 !hold_gate;
  endproperty
  a_hold_after_capture: assert property (p_hold_after_capture)
    else $error("hold strobe not one phase pair after capture");

  property p_block_length;
    $rose(sum_capture_pulse) |->
      $past(acc_run, 2) && !acc_run && sequence_set_reset_latch;
  endproperty
  a_block_length: assert property (p_block_length)
    else $error("capture without a running accumulation");
endmodule

// ---- verif/aos_host_model.sv ----
// host side of the sequencer: load request, word length, bus control
// assumes the bench raises go for one clk; everything moves on clk only
module aos_host_model (
  // clock and reset
  input  wire logic                          clk,
  input  wire logic                          rst,
  // bench requests
  input  wire logic                          go,
  input  wire logic [aos_pkg::WL_WIDTH-1:0]  wl,
  input  wire logic                          oe_req,
  input  wire logic                          pwm_req,
  input  wire logic [11:0]                   pp_val,
  // device pins
  output logic                               load_pulse,
  output logic      [aos_pkg::WL_WIDTH-1:0]  word_length,
  output logic                               output_enable,
  output logic                               program_write_mode,
  output logic      [11:0]                   pp_data
);
  timeunit 1ns;
  timeprecision 1ps;

  // one master clock feeds the device, no phases made here
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      load_pulse         <= 1'b0;
      word_length        <= 3'h0;
      output_enable      <= 1'b0;
      program_write_mode <= 1'b0;
      pp_data            <= 12'h000;
    end else begin
      load_pulse         <= go;
      word_length        <= wl;
      output_enable      <= oe_req;
      program_write_mode <= pwm_req;
      // held constant through a block, so sampling phase cannot matter
      pp_data            <= pp_val;
    end
  end
endmodule

// ---- verif/aos_sequencer_tb.sv ----
// self-checking bench of the accumulate/output sequencer
// assumes one 25 MHz clock and the host model on the control pins
module aos_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic        go = 1'b0;
  logic [2:0]  wl = 3'h0;
  logic        oe_req = 1'b0;
  logic        pwm_req = 1'b0;
  logic [11:0] pp_val = 12'h07B;
  logic [31:0] rdat;
  logic        ld, wl_pin_oe, pwm, ack, irq, pl, clr, sc, rh, dv, roe;
  logic [2:0]  wlp;
  logic [11:0] ppd;
  logic [31:0] dato;
  logic [19:0] rout;
  int          mismatches = 0;
  int          n_tests = 0;

  always #20 clk = ~clk;

  aos_sequencer dut (.clk(clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat),
    .wb_dat_o(dato), .wb_ack_o(ack), .irq(irq), .load_pulse(ld),
    .word_length(wlp), .output_enable(wl_pin_oe),
    .program_write_mode(pwm), .pp_data(ppd), .parallel_load_pulse(pl),
    .accumulator_clear_pulse(clr), .sum_capture_pulse(sc),
    .result_hold(rh), .data_valid(dv), .result_out(rout),
    .result_oe(roe));

  aos_host_model host (.clk(clk), .rst(rst), .go(go), .wl(wl),
    .oe_req(oe_req), .pwm_req(pwm_req), .pp_val(pp_val),
    .load_pulse(ld), .word_length(wlp), .output_enable(wl_pin_oe),
    .program_write_mode(pwm), .pp_data(ppd));

  ////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic print_verdict;
    $display("mismatches %0d of %0d checks", mismatches, n_tests);
    if (mismatches == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // entered just after a rising edge; leaves one idle cycle behind
  task automatic wb_xfer(input logic w, input logic [7:0] a,
                         input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (n >= 50) check("wb ack", 32'h0, 32'h1);
    r = dato;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset_regs;
    wb_xfer(1'b0, aos_pkg::REG_CTRL, 32'h0, rdat);
    check("ctrl reset", rdat, aos_pkg::CTRL_RESET);
    wb_xfer(1'b0, aos_pkg::REG_MASK, 32'h0, rdat);
    check("mask reset", rdat, aos_pkg::MASK_RESET);
    wb_xfer(1'b0, aos_pkg::REG_STATUS, 32'h0, rdat);
    check("status reset", rdat, 32'h0);
    wb_xfer(1'b0, aos_pkg::REG_STATE, 32'h0, rdat);
    check("state idle", rdat, 32'h0);
    wb_xfer(1'b1, 8'h3C, 32'h5A5A_5A5A, rdat);
    wb_xfer(1'b0, 8'h3C, 32'h0, rdat);
    check("unmapped", rdat, 32'h0);
    check("oe reset", {31'h0, roe}, 32'h0);
  endtask

  // one block; a second load mid-block when again is set
  task automatic t_block(input logic [2:0] code, input logic again);
    int t, t_pl, t_sc, t_rh, n_rh, n_hi, b;
    logic p_rh;
    t_pl = -1;
    t_sc = -1;
    t_rh = -1;
    n_rh = 0;
    n_hi = 0;
    p_rh = 1'b0;
    b = code + 1;
    wl <= code;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    for (t = 0; t < 60; t++) begin
      @(posedge clk);
      if (again && t == 6) go <= 1'b1;
      if (again && t == 7) go <= 1'b0;
      if (pl === 1'b1 && t_pl < 0) t_pl = t;
      if (sc === 1'b1 && t_sc < 0) t_sc = t;
      if (rh === 1'b1 && p_rh !== 1'b1) begin
        n_rh++;
        if (t_rh < 0) t_rh = t;
      end
      if (rh === 1'b1) n_hi++;
      if (dv !== rh) check("valid vs hold", {31'h0, dv}, {31'h0, rh});
      if (clr !== pl) check("clear vs load", {31'h0, clr}, {31'h0, pl});
      p_rh = rh;
    end
    check("capture time", 32'(t_sc - t_pl), 32'(2 * b + 2));
    check("hold time", 32'(t_rh - t_pl), 32'(2 * b + 4));
    check("hold count", 32'(n_rh), 32'h1);
    check("hold width", 32'(n_hi), 32'h2);
    check("result pins", {12'h0, rout}, 32'(123 * ((1 << b) - 1)));
    wb_xfer(1'b0, aos_pkg::REG_RESULT, 32'h0, rdat);
    check("result reg", rdat, 32'(123 * ((1 << b) - 1)));
  endtask

  task automatic t_all_lengths;
    for (int c = 0; c < 8; c++) t_block(3'(c), 1'b0);
  endtask

  task automatic t_overrun_irq;
    t_block(3'h7, 1'b1);
    wb_xfer(1'b0, aos_pkg::REG_STATUS, 32'h0, rdat);
    check("status overrun", rdat, 32'h3);
    check("irq masked", {31'h0, irq}, 32'h0);
    wb_xfer(1'b1, aos_pkg::REG_MASK, 32'h2, rdat);
    repeat (2) @(posedge clk);
    check("irq raised", {31'h0, irq}, 32'h1);
    wb_xfer(1'b1, aos_pkg::REG_STATUS, 32'h3, rdat);
    repeat (2) @(posedge clk);
    check("irq cleared", {31'h0, irq}, 32'h0);
    wb_xfer(1'b0, aos_pkg::REG_STATUS, 32'h0, rdat);
    check("status cleared", rdat, 32'h0);
  endtask

  task automatic t_disabled;
    int n;
    n = 0;
    wb_xfer(1'b1, aos_pkg::REG_CTRL, 32'h0, rdat);
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    repeat (30) begin
      @(posedge clk);
      if (pl === 1'b1) n++;
    end
    check("disabled load", 32'(n), 32'h0);
    wb_xfer(1'b1, aos_pkg::REG_CTRL, 32'h1, rdat);
  endtask

  // every pairing of enable and program-write mode
  task automatic t_bus;
    for (int i = 0; i < 4; i++) begin
      oe_req <= i[0];
      pwm_req <= i[1];
      repeat (3) @(posedge clk);
      check("bus drive", {31'h0, roe}, {31'h0, i == 1});
    end
    oe_req <= 1'b0;
    pwm_req <= 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset_regs();
    t_bus();
    t_all_lengths();
    t_overrun_irq();
    t_disabled();
    t_block(3'h2, 1'b0);
    print_verdict();
  end

  // whole run is well under 2000 cycles
  initial begin
    #(40 * 20000);
    mismatches++;
    print_verdict();
  end
endmodule
